// ===== bench/dpd_pll_side.sv
// Reference source and oscillator model driving the differential input pairs.
`timescale 1ns/1ps
`default_nettype none
module dpd_pll_side (
   input wire logic clk,
   output logic ref_pos,
   output logic ref_neg,
   output logic osc_pos,
   output logic osc_neg
);
   // Both sources rest low so that settings only change between bursts.
   initial begin
      ref_pos = 1'b0;
      ref_neg = 1'b1;
      osc_pos = 1'b0;
      osc_neg = 1'b1;
   end

   // The negative leg always carries the complement of the positive one.
   task automatic set_ref(input logic v);
      ref_pos <= v;
      ref_neg <= !v;
   endtask

   task automatic set_osc(input logic v);
      osc_pos <= v;
      osc_neg <= !v;
   endtask

   // One rise on each source, the second one lag cycles after the first.
   task automatic pair(input logic ref_first, input int lag);
      if (lag > 0) begin
         if (ref_first) begin
            set_ref(1'b1);
         end else begin
            set_osc(1'b1);
         end
         repeat (lag) @(posedge clk);
      end
      set_ref(1'b1);
      set_osc(1'b1);
      repeat (4) @(posedge clk);
      set_ref(1'b0);
      set_osc(1'b0);
      repeat (10) @(posedge clk);
   endtask

   // Square waves on both sources, each level held two cycles.
   task automatic run(input int n);
      repeat (n) begin
         set_ref(1'b1);
         set_osc(1'b1);
         repeat (2) @(posedge clk);
         set_ref(1'b0);
         set_osc(1'b0);
         repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== bench/dpd_top_bench.sv
// Self-checking bench for the dual prescaler phase detector.
`timescale 1ns/1ps
`default_nettype none
module dpd_top_bench
   import dpd_pkg::*;
;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic HSEL = 1'b1;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT, HRESP, rp, rn, op, on, up_p, up_n, dn_p, dn_n, tr, to;
   logic rt_q = 1'b0;
   logic ot_q = 1'b0;
   logic [13:0] cur;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int up_cnt = 0, dn_cnt = 0, rt_cnt = 0, ot_cnt = 0;

   dpd_top i_dpd_top (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .REFERENCE_IN_POS(rp),
      .REFERENCE_IN_NEG(rn), .OSCILLATOR_IN_POS(op), .OSCILLATOR_IN_NEG(on),
      .UP_PULSE_OUT_POS(up_p), .UP_PULSE_OUT_NEG(up_n), .DOWN_PULSE_OUT_POS(dn_p),
      .DOWN_PULSE_OUT_NEG(dn_n), .DIVIDED_REFERENCE_TAP(tr), .DIVIDED_OSCILLATOR_TAP(to),
      .PUMP_CURRENT_UA(cur));
   dpd_pll_side i_dpd_pll_side (.clk(CLK), .ref_pos(rp), .ref_neg(rn), .osc_pos(op),
      .osc_neg(on));

   always #12.5 CLK = !CLK;

   // Counts pulse cycles and tap rises, and cuts a hang short.
   always @(posedge CLK) begin
      cyc++;
      if (up_p === 1'b1) up_cnt++;
      if (dn_p === 1'b1) dn_cnt++;
      if (tr === 1'b1 && rt_q === 1'b0) rt_cnt++;
      if (to === 1'b1 && ot_q === 1'b0) ot_cnt++;
      rt_q = tr;
      ot_q = to;
      if (cyc == 10000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single word transfer; waits on the slave's ready in both phases.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      HTRANS <= DPD_HTRANS_NONSEQ;
      HADDR <= {24'h000000, a};
      HWRITE <= w;
      HSIZE <= DPD_HSIZE_WORD;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      q = HRDATA;
   endtask

   task automatic put(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Every register reads zero after reset; an unmapped place ignores writes.
   task automatic t_reset_values();
      logic [31:0] q;
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, 8'(4 * i), 32'h0, q);
         check(q, 32'h0);
      end
      check({18'h0, cur}, 32'h0);
      put(8'h40, 32'hffffffff);
      bus(1'b0, 8'h40, 32'h0, q);
      check(q, 32'h0);
      check({31'h0, HRESP}, 32'h0);
   endtask

   // Leading, lagging and coincident edges under both pump senses.
   task automatic t_lead_lag();
      int u, d, lg, eu, ed;
      for (int inv = 0; inv < 2; inv++) begin
         put(DPD_OFS_PUMP_CTRL, 32'(inv << DPD_INVERT_BIT));
         for (int c = 0; c < 4; c++) begin
            lg = (c == 3) ? 0 : (c < 2 ? 3 : 1);
            eu = (c != 1) ? lg : 0;
            ed = (c == 1) ? lg : 0;
            u = up_cnt;
            d = dn_cnt;
            i_dpd_pll_side.pair(c != 1, lg);
            check(32'(up_cnt - u), 32'(inv ? ed : eu));
            check(32'(dn_cnt - d), 32'(inv ? eu : ed));
         end
      end
   endtask

   // Every gain code gives its step multiple, full scale the maximum.
   task automatic t_gain();
      logic [31:0] q, e;
      for (int g = 0; g < 16; g++) begin
         e = (g == 15) ? 32'(DPD_CUR_MAX_UA) : 32'(g * 750);
         put(DPD_OFS_PUMP_CTRL, 32'(g));
         bus(1'b0, DPD_OFS_PUMP_LEVEL, 32'h0, q);
         check(q, e);
         repeat (2) @(posedge CLK);
         check({18'h0, cur}, e);
      end
   endtask

   // New words take effect at a boundary; taps are counted over whole periods.
   task automatic t_divide(input logic [6:0] rr, input logic [6:0] orr, input int w);
      int r, o;
      put(DPD_OFS_REF_RATIO, 32'(rr));
      put(DPD_OFS_OSC_RATIO, 32'(orr));
      i_dpd_pll_side.run(127);
      r = rt_cnt;
      o = ot_cnt;
      i_dpd_pll_side.run(w);
      check(32'(rt_cnt - r), 32'(w / (rr == 7'h00 ? 1 : int'(rr))));
      check(32'(ot_cnt - o), 32'(w / int'(orr)));
   endtask

   // Reset, then each scenario in turn.
   initial begin
      repeat (16) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      t_reset_values();
      t_lead_lag();
      t_gain();
      t_divide(7'h00, 7'h01, 2);
      t_divide(7'h40, 7'h02, 128);
      t_divide(7'h7f, 7'h05, 635);
      end_of_test();
   end
endmodule
`default_nettype wire

// ===== bench/dpd_top_properties.sv
// Concurrent checks on the dual prescaler phase detector top ports.
`timescale 1ns/1ps
`default_nettype none
module dpd_top_properties
   import dpd_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic REFERENCE_IN_POS,
   input wire logic REFERENCE_IN_NEG,
   input wire logic OSCILLATOR_IN_POS,
   input wire logic OSCILLATOR_IN_NEG,
   input wire logic UP_PULSE_OUT_POS,
   input wire logic UP_PULSE_OUT_NEG,
   input wire logic DOWN_PULSE_OUT_POS,
   input wire logic DOWN_PULSE_OUT_NEG,
   input wire logic DIVIDED_REFERENCE_TAP,
   input wire logic [13:0] PUMP_CURRENT_UA
);
   logic ap_ff;
   logic gu_ff;
   logic [7:0] ad_ff;
   logic [6:0] rr_ff;
   logic [6:0] or_ff;
   logic [4:0] pc_ff;
   wire rl = REFERENCE_IN_POS & ~REFERENCE_IN_NEG;
   wire ol = OSCILLATOR_IN_POS & ~OSCILLATOR_IN_NEG;
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);

   // Shadow copies of the control words, taken from completed word writes.
   always_ff @(posedge CLK) begin
      gu_ff <= 1'b0;
      if (SRST) begin
         ap_ff <= 1'b0;
         rr_ff <= 7'h00;
         or_ff <= 7'h00;
         pc_ff <= 5'h00;
      end else if (HREADY) begin
         ap_ff <= HSEL && HWRITE && HTRANS == DPD_HTRANS_NONSEQ && HSIZE == DPD_HSIZE_WORD;
         ad_ff <= HADDR[7:0];
         if (ap_ff && ad_ff == DPD_OFS_REF_RATIO) rr_ff <= HWDATA[6:0];
         if (ap_ff && ad_ff == DPD_OFS_OSC_RATIO) or_ff <= HWDATA[6:0];
         if (ap_ff && ad_ff == DPD_OFS_PUMP_CTRL) begin
            pc_ff <= HWDATA[4:0];
            gu_ff <= 1'b1;
         end
      end
   end

   chk_up_complement: assert property (UP_PULSE_OUT_NEG == !UP_PULSE_OUT_POS)
      else $error("up pair legs not complementary");
   chk_down_complement: assert property (DOWN_PULSE_OUT_NEG == !DOWN_PULSE_OUT_POS)
      else $error("down pair legs not complementary");
   chk_never_both: assert property (!(UP_PULSE_OUT_POS && DOWN_PULSE_OUT_POS))
      else $error("up and down pulses high together");
   chk_reset_quiet: assert property (disable iff (1'b0)
      SRST |=> !UP_PULSE_OUT_POS && !DOWN_PULSE_OUT_POS && PUMP_CURRENT_UA == 14'h0000)
      else $error("outputs not quiet after reset");
   chk_bus_wait: assert property (
      HSEL && HREADY && HTRANS == DPD_HTRANS_NONSEQ |=> !HREADYOUT ##1 HREADYOUT)
      else $error("control word transfer not one wait state");
   chk_gain_scale: assert property (
      gu_ff && pc_ff[3:0] != DPD_GAIN_FULL
      |-> ##[0:3] PUMP_CURRENT_UA == 14'(pc_ff[3:0]) * DPD_CUR_STEP_UA)
      else $error("pump current not gain times step");
   chk_gain_full: assert property (
      gu_ff && pc_ff[3:0] == DPD_GAIN_FULL |-> ##[0:3] PUMP_CURRENT_UA == DPD_CUR_MAX_UA)
      else $error("full scale pump current wrong");
   chk_ref_lead: assert property (
      rr_ff <= 7'h01 && or_ff <= 7'h01 && $rose(rl) && !ol ##1 !ol [*2]
      |-> ##[2:4] (pc_ff[4] ? DOWN_PULSE_OUT_POS : UP_PULSE_OUT_POS))
      else $error("leading reference gave no pulse");
   chk_osc_lead: assert property (
      rr_ff <= 7'h01 && or_ff <= 7'h01 && $rose(ol) && !rl ##1 !rl [*2]
      |-> ##[2:4] (pc_ff[4] ? UP_PULSE_OUT_POS : DOWN_PULSE_OUT_POS))
      else $error("leading oscillator gave no pulse");
   chk_tap_unity: assert property (
      rr_ff <= 7'h01 && $rose(rl) |-> ##[2:4] DIVIDED_REFERENCE_TAP)
      else $error("unity reference tap does not follow input");
endmodule

bind dpd_top dpd_top_properties i_dpd_top_properties (.CLK(CLK), .SRST(SRST), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HREADYOUT(HREADYOUT), .REFERENCE_IN_POS(REFERENCE_IN_POS),
   .REFERENCE_IN_NEG(REFERENCE_IN_NEG), .OSCILLATOR_IN_POS(OSCILLATOR_IN_POS),
   .OSCILLATOR_IN_NEG(OSCILLATOR_IN_NEG), .UP_PULSE_OUT_POS(UP_PULSE_OUT_POS),
   .UP_PULSE_OUT_NEG(UP_PULSE_OUT_NEG), .DOWN_PULSE_OUT_POS(DOWN_PULSE_OUT_POS),
   .DOWN_PULSE_OUT_NEG(DOWN_PULSE_OUT_NEG), .DIVIDED_REFERENCE_TAP(DIVIDED_REFERENCE_TAP),
   .PUMP_CURRENT_UA(PUMP_CURRENT_UA));
`default_nettype wire

// ===== design/dpd_phase_detector.sv
// Tri-state phase-frequency detector on divided edge pulses.
`timescale 1ns/1ps
`default_nettype none
module dpd_phase_detector
   import dpd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ref_tick,
   input wire logic osc_tick,
   output logic up,
   output logic down
);
   logic up_ff;
   logic down_ff;
   logic nxt_up;
   logic nxt_down;

   // Each edge sets its flag; once both are set they clear together.
   always_comb begin
      nxt_up = up_ff | ref_tick;
      nxt_down = down_ff | osc_tick;
      if (nxt_up && nxt_down) begin
         nxt_up = 1'b0;
         nxt_down = 1'b0;
      end
   end

   // Detector state; the clear path is one cycle, the narrowest pulse possible.
   always_ff @(posedge clk) begin
      if (srst) begin
         up_ff <= 1'b0;
         down_ff <= 1'b0;
      end else begin
         up_ff <= nxt_up;
         down_ff <= nxt_down;
      end
   end

   assign up = up_ff;
   assign down = down_ff;
endmodule
`default_nettype wire

// ===== design/dpd_pkg.sv
// Shared constants of the dual prescaler phase detector.
package dpd_pkg;
   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] DPD_OFS_REF_RATIO = 8'h00;
   localparam logic [7:0] DPD_OFS_OSC_RATIO = 8'h04;
   localparam logic [7:0] DPD_OFS_PUMP_CTRL = 8'h08;
   localparam logic [7:0] DPD_OFS_STATUS = 8'h0c;
   localparam logic [7:0] DPD_OFS_PUMP_LEVEL = 8'h10;
   localparam logic [7:0] DPD_OFS_EDGE_COUNT = 8'h14;

   // Field layout.
   localparam int DPD_RATIO_W = 7;
   localparam int DPD_GAIN_W = 4;
   localparam int DPD_GAIN_LSB = 0;
   localparam int DPD_INVERT_BIT = 4;
   localparam int DPD_ST_REF_TAP = 0;
   localparam int DPD_ST_OSC_TAP = 1;
   localparam int DPD_ST_UP = 2;
   localparam int DPD_ST_DOWN = 3;
   localparam int DPD_CUR_W = 14;

   // Reset values: an open control input reads as zero.
   localparam logic [6:0] DPD_RATIO_RST = 7'h00;
   localparam logic [3:0] DPD_GAIN_RST = 4'h0;
   localparam logic DPD_INVERT_RST = 1'b0;

   // Pump current scale in microamps.
   localparam logic [13:0] DPD_CUR_STEP_UA = 14'h02ee;
   localparam logic [13:0] DPD_CUR_MAX_UA = 14'h2ee0;
   localparam logic [3:0] DPD_GAIN_FULL = 4'hf;

   // Timing: clock rate and narrowest pump pulse.
   localparam longint DPD_CLK_HZ = 40000000;
   localparam longint DPD_MIN_PULSE_PS = 100;
   localparam longint DPD_MIN_PULSE_RAW =
      (DPD_MIN_PULSE_PS * DPD_CLK_HZ + 64'd999999999999) / 64'd1000000000000;
   localparam int DPD_MIN_PULSE_CYC =
      (DPD_MIN_PULSE_RAW < 1) ? 1 : int'(DPD_MIN_PULSE_RAW);

   // AHB-Lite encodings.
   localparam logic [1:0] DPD_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] DPD_HSIZE_WORD = 3'h2;

   // Bus slave sequence.
   typedef enum logic [1:0] {DPD_BUS_IDLE, DPD_BUS_DATA} dpd_bus_t;
endpackage

// ===== design/dpd_prescaler.sv
// Programmable integer prescaler, divide by 1 to 127, with monitor tap.
`timescale 1ns/1ps
`default_nettype none
module dpd_prescaler
   import dpd_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic level,
   input wire logic [6:0] ratio,
   output logic tick,
   output logic tap
);
   logic prev_ff;
   logic [6:0] cnt_ff;
   logic [6:0] cur_n_ff;
   logic tick_ff;
   logic tap_ff;
   logic rise;
   logic [6:0] eff_n;
   logic [6:0] half_n;

   // A zero word divides by one; otherwise the word is the modulus.
   assign eff_n = (ratio == 7'h00) ? 7'h01 : ratio;
   assign rise = level & ~prev_ff;

   // High-time threshold, summed one bit wider so that a modulus of 127 does not wrap.
   assign half_n = 7'((8'(cur_n_ff) + 8'h01) >> 1);

   // Input edge detector on the already synchronised level.
   always_ff @(posedge clk) begin
      if (srst) begin
         prev_ff <= 1'b0;
      end else begin
         prev_ff <= level;
      end
   end

   // Edge counter; the new modulus is taken only at the cycle boundary.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff <= 7'h00;
         cur_n_ff <= 7'h01;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (rise) begin
            if (cnt_ff >= cur_n_ff - 7'h01) begin
               cnt_ff <= 7'h00;
               cur_n_ff <= eff_n;
               tick_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 7'h01;
            end
         end
      end
   end

   // Monitor tap: follows the input at divide by one, else a near-square wave.
   always_ff @(posedge clk) begin
      if (srst) begin
         tap_ff <= 1'b0;
      end else if (cur_n_ff == 7'h01) begin
         tap_ff <= level;
      end else begin
         tap_ff <= (cnt_ff < half_n);
      end
   end

   assign tick = tick_ff;
   assign tap = tap_ff;
endmodule
`default_nettype wire

// ===== design/dpd_top.sv
// Dual prescaler phase detector with AHB-Lite control registers.
//
// Operation
// R1 - Two independent prescalers divide reference and oscillator, each with its own word.
// R2 - Each prescaler divides by any integer modulus from one to 127.
// R3 - An all-zero ratio word divides by one, passing the input unchanged.
// R4 - The ratio is the unsigned value of the word, bit six most significant.
// R5 - The oscillator prescaler uses its own word with the same encoding.
// R6 - Ratio words may change while running and take effect at once; here a new ratio takes effect at the next terminal count.
// R7 - The detector compares divided signals and drives up and down outputs.
// R8 - Leading reference gives up pulse, lagging gives down; both clear when both arrive.
// R9 - The detector clear path allows the narrowest possible pump pulse.
// R10 - A 4-bit gain code sets the pump pulse amplitude.
// R11 - Full-scale gain gives the maximum pump current of 12 mA.
// R12 - Pump current scales by 0.75 mA per code step, zero at code zero.
// R13 - Polarity bit high swaps up and down outputs; low leaves them normal.
// R14 - All control inputs share one logic and read as zero when left alone.
// R15 - Divided reference and oscillator each appear on a monitor output.
// R16 - The controller holds settings stable around each prescaler terminal count.
`timescale 1ns/1ps
`default_nettype none
module dpd_top
   import dpd_pkg::*;
(
   input wire logic CLK,
   input wire logic SRST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic REFERENCE_IN_POS,
   input wire logic REFERENCE_IN_NEG,
   input wire logic OSCILLATOR_IN_POS,
   input wire logic OSCILLATOR_IN_NEG,
   output logic UP_PULSE_OUT_POS,
   output logic UP_PULSE_OUT_NEG,
   output logic DOWN_PULSE_OUT_POS,
   output logic DOWN_PULSE_OUT_NEG,
   output logic DIVIDED_REFERENCE_TAP,
   output logic DIVIDED_OSCILLATOR_TAP,
   output logic [13:0] PUMP_CURRENT_UA
);
   // Differential receiver: the pin pair reads high when the positive leg wins.
   // Equal legs read low, so an open pair never
   // fakes a rising edge into a prescaler.
   function automatic logic diff_level(input logic pos, input logic neg);
      diff_level = pos & ~neg;
   endfunction

   // Pump current in microamps for a gain code, linear with a full-scale cap.
   // The top code reports the stated maximum,
   // not fifteen plain steps.
   function automatic logic [13:0] gain_to_ua(input logic [3:0] code);
      logic [17:0] prod;
      prod = 18'(code) * 18'(DPD_CUR_STEP_UA);
      if (code == DPD_GAIN_FULL) begin
         gain_to_ua = DPD_CUR_MAX_UA;
      end else begin
         gain_to_ua = prod[13:0];
      end
   endfunction

   // Register address decode on the low byte of the captured address.
   // Nonzero upper bits alias nothing and read zero.
   function automatic logic is_reg(input logic [31:0] addr, input logic [7:0] ofs);
      is_reg = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
   endfunction

   // Pin synchronisers: the first stage feeds only the second.
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;

   // Control registers.
   logic [6:0] ref_ratio_ff;
   logic [6:0] osc_ratio_ff;
   logic [3:0] gain_ff;
   logic pump_sense_invert_ff;

   // Bus slave state.
   dpd_bus_t bus_state_ff;
   logic wr_pend_ff;
   logic [31:0] addr_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic hresp_ff;

   // Datapath outputs.
   logic up_pos_ff;
   logic up_neg_ff;
   logic down_pos_ff;
   logic down_neg_ff;
   logic ref_tap_ff;
   logic osc_tap_ff;
   logic [13:0] pump_ua_ff;
   logic [15:0] ref_cycles_ff;
   logic [15:0] osc_cycles_ff;

   // Internal nets between receivers, prescalers and detector.
   logic ref_level;
   logic osc_level;
   logic ref_tick;
   logic osc_tick;
   logic ref_tap;
   logic osc_tap;
   logic det_up;
   logic det_down;
   logic drive_up;
   logic drive_down;
   logic accept;
   logic [31:0] rd_word;

   // Two-flop synchronisers for the reference and oscillator pin pairs.
   // Only the second stage is read, giving a metastable
   // first stage a full cycle to settle. Each level must
   // last two cycles or its edge may be lost.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
      end else begin
         pin_s1_ff <= {OSCILLATOR_IN_NEG, OSCILLATOR_IN_POS,
                       REFERENCE_IN_NEG, REFERENCE_IN_POS};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // Receiver levels taken from the second stage only.
   assign ref_level = diff_level(pin_s2_ff[0], pin_s2_ff[1]);
   assign osc_level = diff_level(pin_s2_ff[2], pin_s2_ff[3]);

   // Reference path prescaler.
   // A new ratio is taken only at terminal count, so a
   // mid-cycle write never cuts the running cycle.
   dpd_prescaler u_ref_div (
      .clk(CLK),
      .srst(SRST),
      .level(ref_level),
      .ratio(ref_ratio_ff), // R1 R4
      .tick(ref_tick),
      .tap(ref_tap)
   );

   // Oscillator path prescaler with its own word.
   dpd_prescaler u_osc_div (
      .clk(CLK),
      .srst(SRST),
      .level(osc_level),
      .ratio(osc_ratio_ff), // R5
      .tick(osc_tick),
      .tap(osc_tap)
   );

   // Phase-frequency detector on the divided edges.
   // Ticks on one edge cancel: equal phases give no pulse.
   dpd_phase_detector u_pfd (
      .clk(CLK),
      .srst(SRST),
      .ref_tick(ref_tick), // R7
      .osc_tick(osc_tick), // R8
      .up(det_up),
      .down(det_down)
   );

   // Polarity swap exchanges the up and down roles.
   // Swapping before the output flops keeps both legs
   // of a pair in step; status shows the unswapped state.
   assign drive_up = pump_sense_invert_ff ? det_down : det_up; // R13
   assign drive_down = pump_sense_invert_ff ? det_up : det_down; // R13

   // Differential pump outputs, registered; one-cycle pulses pass intact.
   // The narrowest pulse is one clock period, so very
   // narrow phase errors are widened to one cycle.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         up_pos_ff <= 1'b0;
         up_neg_ff <= 1'b1;
         down_pos_ff <= 1'b0;
         down_neg_ff <= 1'b1;
      end else begin
         up_pos_ff <= drive_up; // R9
         up_neg_ff <= ~drive_up;
         down_pos_ff <= drive_down; // R9
         down_neg_ff <= ~drive_down;
      end
   end

   // Monitor taps of the divided signals.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ref_tap_ff <= 1'b0;
         osc_tap_ff <= 1'b0;
      end else begin
         ref_tap_ff <= ref_tap; // R15
         osc_tap_ff <= osc_tap; // R15
      end
   end

   // Pump current follows the gain code.
   // Pulses still go out at gain zero; only this reads zero.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pump_ua_ff <= 14'h0000;
      end else begin
         pump_ua_ff <= gain_to_ua(gain_ff); // R10 R11 R12
      end
   end

   // Divided cycle counters give software a view of both loops.
   // They wrap at the top; software takes differences.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ref_cycles_ff <= 16'h0000;
         osc_cycles_ff <= 16'h0000;
      end else begin
         if (ref_tick) begin
            ref_cycles_ff <= ref_cycles_ff + 16'h0001;
         end
         if (osc_tick) begin
            osc_cycles_ff <= osc_cycles_ff + 16'h0001;
         end
      end
   end

   // A transfer is taken on a selected NONSEQ address phase.
   assign accept = HSEL && HREADY && (HTRANS == DPD_HTRANS_NONSEQ);

   // Bus sequencer: every transfer inserts one wait state in its data phase.
   // The wait state lets the write data stand a full
   // cycle before they land and settles the read mux.
   // No new address phase is taken in the wait state,
   // since the master's ready input is low there.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         bus_state_ff <= DPD_BUS_IDLE;
         hreadyout_ff <= 1'b1;
         wr_pend_ff <= 1'b0;
         addr_ff <= 32'h00000000;
      end else begin
         case (bus_state_ff)
            DPD_BUS_IDLE: begin
               if (accept) begin
                  bus_state_ff <= DPD_BUS_DATA;
                  hreadyout_ff <= 1'b0;
                  wr_pend_ff <= HWRITE && (HSIZE == DPD_HSIZE_WORD);
                  addr_ff <= HADDR;
               end
            end
            DPD_BUS_DATA: begin
               bus_state_ff <= DPD_BUS_IDLE;
               hreadyout_ff <= 1'b1;
               wr_pend_ff <= 1'b0;
            end
            default: begin
               bus_state_ff <= DPD_BUS_IDLE;
               hreadyout_ff <= 1'b1;
               wr_pend_ff <= 1'b0;
            end
         endcase
      end
   end

   // The slave only ever answers OKAY.
   // Unmapped places and narrow writes are ignored quietly.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         hresp_ff <= 1'b0;
      end else begin
         hresp_ff <= 1'b0;
      end
   end

   // Control registers; writes land in the data phase, ratio words acting at the next terminal count.
   // Reset clears them all, as open inputs read zero:
   // divide by one, no current and no polarity swap.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ref_ratio_ff <= DPD_RATIO_RST; // R14
         osc_ratio_ff <= DPD_RATIO_RST; // R14
         gain_ff <= DPD_GAIN_RST; // R14
         pump_sense_invert_ff <= DPD_INVERT_RST; // R14
      end else if (wr_pend_ff && (bus_state_ff == DPD_BUS_DATA)) begin
         if (is_reg(addr_ff, DPD_OFS_REF_RATIO)) begin
            ref_ratio_ff <= HWDATA[DPD_RATIO_W-1:0]; // R2 R3 R6
         end else if (is_reg(addr_ff, DPD_OFS_OSC_RATIO)) begin
            osc_ratio_ff <= HWDATA[DPD_RATIO_W-1:0]; // R5 R6
         end else if (is_reg(addr_ff, DPD_OFS_PUMP_CTRL)) begin
            gain_ff <= HWDATA[DPD_GAIN_LSB +: DPD_GAIN_W]; // R10
            pump_sense_invert_ff <= HWDATA[DPD_INVERT_BIT]; // R13
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   // Only the status word shows live detector state.
   always_comb begin
      rd_word = 32'h00000000;
      if (is_reg(addr_ff, DPD_OFS_REF_RATIO)) begin
         rd_word[DPD_RATIO_W-1:0] = ref_ratio_ff;
      end else if (is_reg(addr_ff, DPD_OFS_OSC_RATIO)) begin
         rd_word[DPD_RATIO_W-1:0] = osc_ratio_ff;
      end else if (is_reg(addr_ff, DPD_OFS_PUMP_CTRL)) begin
         rd_word[DPD_GAIN_LSB +: DPD_GAIN_W] = gain_ff;
         rd_word[DPD_INVERT_BIT] = pump_sense_invert_ff;
      end else if (is_reg(addr_ff, DPD_OFS_STATUS)) begin
         rd_word[DPD_ST_REF_TAP] = ref_tap_ff;
         rd_word[DPD_ST_OSC_TAP] = osc_tap_ff;
         rd_word[DPD_ST_UP] = det_up;
         rd_word[DPD_ST_DOWN] = det_down;
      end else if (is_reg(addr_ff, DPD_OFS_PUMP_LEVEL)) begin
         rd_word[DPD_CUR_W-1:0] = pump_ua_ff;
      end else if (is_reg(addr_ff, DPD_OFS_EDGE_COUNT)) begin
         rd_word = {osc_cycles_ff, ref_cycles_ff};
      end
   end

   // Read data is loaded at the end of the wait state and held after.
   // Holding it lets a slow master take the word late.
   always_ff @(posedge CLK) begin
      if (SRST) begin
         hrdata_ff <= 32'h00000000;
      end else if ((bus_state_ff == DPD_BUS_DATA) && !wr_pend_ff) begin
         hrdata_ff <= rd_word;
      end
   end

   // Every top output comes straight from a flip-flop.
   assign HRDATA = hrdata_ff;
   assign HREADYOUT = hreadyout_ff;
   assign HRESP = hresp_ff;
   assign UP_PULSE_OUT_POS = up_pos_ff;
   assign UP_PULSE_OUT_NEG = up_neg_ff;
   assign DOWN_PULSE_OUT_POS = down_pos_ff;
   assign DOWN_PULSE_OUT_NEG = down_neg_ff;
   assign DIVIDED_REFERENCE_TAP = ref_tap_ff;
   assign DIVIDED_OSCILLATOR_TAP = osc_tap_ff;
   assign PUMP_CURRENT_UA = pump_ua_ff;
endmodule
`default_nettype wire
